// ==== hdl/mau_pkg.sv ====
// Register map, field positions and widths of the multiply-accumulate unit
package mau_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ACC_W = 48;
   localparam int unsigned PROD_W = 32;
   localparam int unsigned APB_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned IDX_W = 6;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL = 6'h00;
   localparam logic [IDX_W-1:0] IDX_OPA = 6'h01;
   localparam logic [IDX_W-1:0] IDX_OPB = 6'h02;
   localparam logic [IDX_W-1:0] IDX_ACC_TOP = 6'h03;
   localparam logic [IDX_W-1:0] IDX_ACC_MID = 6'h04;
   localparam logic [IDX_W-1:0] IDX_ACC_BOT = 6'h05;
   localparam logic [IDX_W-1:0] IDX_RES_HI = 6'h0C;
   localparam logic [IDX_W-1:0] IDX_RES_LO = 6'h0D;

   // Control/status field positions
   localparam int unsigned BIT_UNSIGNED = 0;
   localparam int unsigned BIT_ACCUM = 1;
   localparam int unsigned BIT_NEGSUB = 2;
   localparam int unsigned BIT_ONE_OP = 3;
   localparam int unsigned BIT_SQUARE = 4;
   localparam int unsigned BIT_CLEAR = 5;
   localparam int unsigned BIT_WBLOCK = 6;
   localparam int unsigned BIT_OVF = 7;
   localparam int unsigned CTRL_W = 7;

   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
   localparam logic [ACC_W-1:0] ACC_RESET = 48'h0000_0000_0000;

   // Operand load tracking, one-hot
   typedef enum logic [2:0] {
      MAU_LOAD_NONE = 3'b001,
      MAU_LOAD_HAVE_A = 3'b010,
      MAU_LOAD_HAVE_B = 3'b100
   } mau_load_t;
endpackage : mau_pkg

// ==== hdl/mau_top.sv ====
// Multiply-accumulate unit with APB register access
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RULE_01] Two 16-bit operands, 32-bit read-only result pair, 48-bit three-word accumulator.
// [RULE_02] Multiply plus accumulate or subtract completes within one cycle of trigger.
// [RULE_03] Product of operands is 32 bits, optionally added to or subtracted from accumulator.
// [RULE_04] Software sets operation and operand count before writing triggering operands.
// [RULE_05] Control bits 15 to 8 read zero and ignore writes.
// [RULE_06] Every register resets to 0000h.
// [RULE_07] Read-only overflow flag bit 7 shows overflow of the latest operation.
// [RULE_08] Overflow flag clears on reset, new operation start, and clear-data.
// [RULE_09] Write-block bit 6 at 1 keeps accumulator unchanged; at 0 stores result.
// [RULE_10] Clear-data bit 5 zeroes operands, accumulator, flag, load counter; self-clearing.
// [RULE_11] Square bit 4: writing either operand loads both and starts operation.
// [RULE_12] Operand-count bit 3: 0 needs both operands, 1 triggers on either.
// [RULE_13] Negate bit 2 subtracts when accumulating, otherwise negates the product.
// [RULE_14] Accumulate bit 1 at 0 gives plain or negated multiply, else accumulate.
// [RULE_15] Data-type bit 0: 0 signed two's complement, 1 unsigned.
// [RULE_16] Accumulator: top word bits 47:32, middle 31:16, bottom 15:0; MSB is sign.
// [RULE_17] Result pair shows last result when write-blocked or after multiply-negate.
// [RULE_18] Result pair follows control, operands and accumulator combinationally.
// [RULE_19] Any control write resets operand load counter, operands kept unless clear-data.
// [RULE_20] Accumulator readable one cycle after operation; back-to-back operations accepted.
// [RULE_21] Two-operand mode: rewriting the same operand does not trigger.
// [RULE_22] Signed overflow from sign-carry mismatch; unsigned from carry or borrow out.
// [RULE_23] Operands read back, accumulator words writable, read-only writes ignored.
module mau_top (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [mau_pkg::ADDR_W-1:0] PADDR,
   input wire logic [mau_pkg::APB_W-1:0] PWDATA,
   output logic [mau_pkg::APB_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   logic [mau_pkg::CTRL_W-1:0] ctrl_r;
   logic ovf_r;
   logic [mau_pkg::DATA_W-1:0] opa_r; // [RULE_01]
   logic [mau_pkg::DATA_W-1:0] opb_r;
   logic [mau_pkg::ACC_W-1:0] acc_r; // [RULE_01]
   mau_pkg::mau_load_t load_r;
   logic go_r;
   logic pready_r;
   logic pslverr_r;
   logic [mau_pkg::APB_W-1:0] prdata_r;

   // Bus decode
   logic setup;
   logic wr;
   logic [mau_pkg::IDX_W-1:0] idx;
   logic aligned;
   logic mapped;
   logic wr_ctrl;
   logic wr_opa;
   logic wr_opb;
   logic clear;

   assign setup = PSEL && !PENABLE;
   assign wr = PSEL && PENABLE && pready_r && PWRITE && !pslverr_r;
   assign idx = PADDR[mau_pkg::ADDR_W-1:2];
   assign aligned = (PADDR[1:0] == 2'h0);
   assign wr_ctrl = wr && (idx == mau_pkg::IDX_CTRL);
   assign wr_opa = wr && (idx == mau_pkg::IDX_OPA);
   assign wr_opb = wr && (idx == mau_pkg::IDX_OPB);
   assign clear = wr_ctrl && PWDATA[mau_pkg::BIT_CLEAR];

   always_comb begin
      case (idx)
         mau_pkg::IDX_CTRL, mau_pkg::IDX_OPA, mau_pkg::IDX_OPB,
         mau_pkg::IDX_ACC_TOP, mau_pkg::IDX_ACC_MID, mau_pkg::IDX_ACC_BOT,
         mau_pkg::IDX_RES_HI, mau_pkg::IDX_RES_LO: mapped = aligned;
         default: mapped = 1'b0;
      endcase
   end

   // Control fields
   logic uns;
   logic accum;
   logic negsub;
   logic one_op;
   logic square;
   logic wblock;

   assign uns = ctrl_r[mau_pkg::BIT_UNSIGNED]; // [RULE_15]
   assign accum = ctrl_r[mau_pkg::BIT_ACCUM];
   assign negsub = ctrl_r[mau_pkg::BIT_NEGSUB];
   assign one_op = ctrl_r[mau_pkg::BIT_ONE_OP];
   assign square = ctrl_r[mau_pkg::BIT_SQUARE];
   assign wblock = ctrl_r[mau_pkg::BIT_WBLOCK];

   // Datapath: purely combinational from the stored registers
   logic signed [mau_pkg::DATA_W:0] ext_a;
   logic signed [mau_pkg::DATA_W:0] ext_b;
   logic signed [2*mau_pkg::DATA_W+1:0] prod_full;
   logic [mau_pkg::ACC_W-1:0] prod48;
   logic [mau_pkg::ACC_W:0] sum49;
   logic [mau_pkg::ACC_W-1:0] res48;
   logic ovf_nxt;
   logic sgn_acc;
   logic sgn_prod;

   // [RULE_03] [RULE_15]
   assign ext_a = $signed({~uns & opa_r[mau_pkg::DATA_W-1], opa_r});
   assign ext_b = $signed({~uns & opb_r[mau_pkg::DATA_W-1], opb_r});
   assign prod_full = ext_a * ext_b;
   assign prod48 = {{(mau_pkg::ACC_W-2*mau_pkg::DATA_W-2){prod_full[2*mau_pkg::DATA_W+1]}},
                    prod_full};
   assign sgn_acc = acc_r[mau_pkg::ACC_W-1]; // [RULE_16]
   assign sgn_prod = prod48[mau_pkg::ACC_W-1];

   always_comb begin
      sum49 = {1'b0, acc_r} + {1'b0, prod48};
      res48 = prod48;
      ovf_nxt = 1'b0;
      if (accum) begin // [RULE_14]
         if (negsub) begin
            sum49 = {1'b0, acc_r} - {1'b0, prod48}; // [RULE_13]
         end
         res48 = sum49[mau_pkg::ACC_W-1:0];
         if (uns) begin
            ovf_nxt = sum49[mau_pkg::ACC_W]; // [RULE_22]
         end else begin
            // Sign-carry mismatch shows as operand signs versus result sign
            ovf_nxt = ((sgn_acc ^ sgn_prod) == negsub) &&
                      (res48[mau_pkg::ACC_W-1] != sgn_acc); // [RULE_22]
         end
      end else if (negsub) begin
         res48 = mau_pkg::ACC_RESET - prod48; // [RULE_13]
         ovf_nxt = uns; // [RULE_07]
      end
   end

   // Operand load tracking
   logic trigger;
   mau_pkg::mau_load_t load_nxt;

   always_comb begin
      trigger = 1'b0;
      load_nxt = load_r;
      if (wr_ctrl) begin
         load_nxt = mau_pkg::MAU_LOAD_NONE; // [RULE_19]
      end else if (wr_opa || wr_opb) begin
         if (square || one_op) begin // [RULE_11] [RULE_12]
            trigger = 1'b1;
            load_nxt = mau_pkg::MAU_LOAD_NONE;
         end else begin
            case (load_r)
               mau_pkg::MAU_LOAD_HAVE_A: begin
                  trigger = wr_opb; // [RULE_21]
                  load_nxt = wr_opb ? mau_pkg::MAU_LOAD_NONE : mau_pkg::MAU_LOAD_HAVE_A;
               end
               mau_pkg::MAU_LOAD_HAVE_B: begin
                  trigger = wr_opa; // [RULE_21]
                  load_nxt = wr_opa ? mau_pkg::MAU_LOAD_NONE : mau_pkg::MAU_LOAD_HAVE_B;
               end
               default: begin
                  load_nxt = wr_opa ? mau_pkg::MAU_LOAD_HAVE_A : mau_pkg::MAU_LOAD_HAVE_B;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         load_r <= mau_pkg::MAU_LOAD_NONE;
      end else if (clear) begin
         load_r <= mau_pkg::MAU_LOAD_NONE; // [RULE_10]
      end else begin
         load_r <= load_nxt; // [RULE_12]
      end
   end

   // Operation runs in the cycle after the last operand lands
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         go_r <= 1'b0;
      end else begin
         go_r <= trigger; // [RULE_02] [RULE_20]
      end
   end

   // Control register; clear-data is never stored so it reads back as zero
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_r <= {mau_pkg::CTRL_W{1'b0}}; // [RULE_06]
      end else if (wr_ctrl) begin
         ctrl_r <= PWDATA[mau_pkg::CTRL_W-1:0] & ~(7'h01 << mau_pkg::BIT_CLEAR); // [RULE_05] [RULE_10]
      end
   end

   // Overflow flag; the operation result wins over a same-cycle clear
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ovf_r <= 1'b0; // [RULE_08]
      end else if (go_r) begin
         ovf_r <= ovf_nxt; // [RULE_07] [RULE_08]
      end else if (clear) begin
         ovf_r <= 1'b0; // [RULE_08]
      end
   end

   // Operands
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         opa_r <= mau_pkg::REG_RESET;
         opb_r <= mau_pkg::REG_RESET;
      end else if (clear) begin
         opa_r <= mau_pkg::REG_RESET; // [RULE_10]
         opb_r <= mau_pkg::REG_RESET;
      end else if ((wr_opa || wr_opb) && square) begin
         opa_r <= PWDATA[mau_pkg::DATA_W-1:0]; // [RULE_11]
         opb_r <= PWDATA[mau_pkg::DATA_W-1:0];
      end else begin
         if (wr_opa) begin
            opa_r <= PWDATA[mau_pkg::DATA_W-1:0];
         end
         if (wr_opb) begin
            opb_r <= PWDATA[mau_pkg::DATA_W-1:0];
         end
      end
   end

   // Accumulator; a finishing operation takes precedence over a direct word write
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_r <= mau_pkg::ACC_RESET; // [RULE_06]
      end else if (clear) begin
         acc_r <= mau_pkg::ACC_RESET; // [RULE_10]
      end else if (go_r && !wblock) begin
         acc_r <= res48; // [RULE_09]
      end else if (wr) begin
         case (idx)
            mau_pkg::IDX_ACC_TOP: acc_r[47:32] <= PWDATA[mau_pkg::DATA_W-1:0]; // [RULE_16] [RULE_23]
            mau_pkg::IDX_ACC_MID: acc_r[31:16] <= PWDATA[mau_pkg::DATA_W-1:0];
            mau_pkg::IDX_ACC_BOT: acc_r[15:0] <= PWDATA[mau_pkg::DATA_W-1:0];
            default: acc_r <= acc_r;
         endcase
      end
   end

   // APB answer: ready in the first access cycle, read data captured at setup
   logic [mau_pkg::DATA_W-1:0] rd_mux;

   always_comb begin
      case (idx)
         mau_pkg::IDX_CTRL: rd_mux = {8'h00, ovf_r, ctrl_r}; // [RULE_05] [RULE_07]
         mau_pkg::IDX_OPA: rd_mux = opa_r; // [RULE_23]
         mau_pkg::IDX_OPB: rd_mux = opb_r;
         mau_pkg::IDX_ACC_TOP: rd_mux = acc_r[47:32];
         mau_pkg::IDX_ACC_MID: rd_mux = acc_r[31:16];
         mau_pkg::IDX_ACC_BOT: rd_mux = acc_r[15:0];
         mau_pkg::IDX_RES_HI: rd_mux = res48[31:16]; // [RULE_17] [RULE_18]
         mau_pkg::IDX_RES_LO: rd_mux = res48[15:0];
         default: rd_mux = mau_pkg::REG_RESET;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= {mau_pkg::APB_W{1'b0}};
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !mapped;
         if (setup) begin
            prdata_r <= (mapped && !PWRITE) ? {16'h0000, rd_mux} : {mau_pkg::APB_W{1'b0}};
         end
      end
   end

   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign PRDATA = prdata_r;

   // Checks
   property p_reserved_zero;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (setup && !PWRITE && PADDR == 8'h00) |=> (PRDATA[31:8] == 24'h000000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [RULE_05]
      else $error("reserved control bits not zero");

   property p_one_cycle;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (trigger && !clear) |=> go_r ##1 !go_r || $past(trigger);
   endproperty
   a_one_cycle: assert property (p_one_cycle) // [RULE_02]
      else $error("operation not run one cycle after trigger");

   property p_acc_store;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (go_r && !wblock && !clear) |=> (acc_r == $past(res48));
   endproperty
   a_acc_store: assert property (p_acc_store) // [RULE_09]
      else $error("accumulator missed operation result");

   property p_acc_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (go_r && wblock && !wr) |=> $stable(acc_r);
   endproperty
   a_acc_hold: assert property (p_acc_hold) // [RULE_09]
      else $error("write-blocked accumulator changed");

   property p_clear_all;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (clear && !go_r) |=> (opa_r == 16'h0000 && opb_r == 16'h0000 && acc_r == 48'h0 &&
                            !ovf_r && load_r == mau_pkg::MAU_LOAD_NONE && !ctrl_r[5]);
   endproperty
   a_clear_all: assert property (p_clear_all) // [RULE_10]
      else $error("clear-data left state behind");

   property p_ovf_update;
      @(posedge CORE_CLK) disable iff (!RST_N)
      go_r |=> (ovf_r == $past(ovf_nxt));
   endproperty
   a_ovf_update: assert property (p_ovf_update) // [RULE_08]
      else $error("overflow flag not refreshed by operation");

   property p_square_both;
      @(posedge CORE_CLK) disable iff (!RST_N)
      ((wr_opa || wr_opb) && square && !clear) |=> (opa_r == opb_r) && go_r;
   endproperty
   a_square_both: assert property (p_square_both) // [RULE_11]
      else $error("square write did not load both operands");

   property p_two_op_wait;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (wr_opa && !square && !one_op && load_r != mau_pkg::MAU_LOAD_HAVE_B) |=>
         !go_r && load_r == mau_pkg::MAU_LOAD_HAVE_A;
   endproperty
   a_two_op_wait: assert property (p_two_op_wait) // [RULE_12]
      else $error("first operand started an operation");

   property p_ctrl_resets_load;
      @(posedge CORE_CLK) disable iff (!RST_N)
      wr_ctrl |=> (load_r == mau_pkg::MAU_LOAD_NONE);
   endproperty
   a_ctrl_resets_load: assert property (p_ctrl_resets_load) // [RULE_19]
      else $error("control write kept load counter");

   property p_unsigned_negate;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (go_r && uns && negsub && !accum) |=> ovf_r;
   endproperty
   a_unsigned_negate: assert property (p_unsigned_negate) // [RULE_07]
      else $error("unsigned negate did not flag overflow");

   property p_ready_pulse;
      @(posedge CORE_CLK) disable iff (!RST_N)
      setup |=> PREADY ##1 !PREADY;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready not a single access cycle");

   property p_same_operand;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (wr_opa && !square && !one_op && load_r == mau_pkg::MAU_LOAD_HAVE_A) |=>
         !go_r && load_r == mau_pkg::MAU_LOAD_HAVE_A;
   endproperty
   a_same_operand: assert property (p_same_operand) // [RULE_21]
      else $error("rewritten operand started an operation");

   property p_ro_write_ignored;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (wr && (idx == mau_pkg::IDX_RES_HI || idx == mau_pkg::IDX_RES_LO) && !go_r) |=>
         $stable(acc_r) && $stable(opa_r) && $stable(opb_r) && $stable(ctrl_r);
   endproperty
   a_ro_write_ignored: assert property (p_ro_write_ignored) // [RULE_23]
      else $error("write to result word changed state");

endmodule : mau_top
`default_nettype wire

// ==== test/test_mau_top.sv ====
// Self-checking APB testbench for the multiply-accumulate unit
`timescale 1ns/100ps
`default_nettype none
module test_mau_top;
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [mau_pkg::ADDR_W-1:0] PADDR = 8'h00;
   logic [mau_pkg::APB_W-1:0] PWDATA = 32'h0000_0000;
   wire logic [mau_pkg::APB_W-1:0] PRDATA;
   wire logic PREADY;
   wire logic PSLVERR;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [47:0] acc_m;
   logic [15:0] a_m;
   logic [15:0] b_m;
   logic [7:0] ctrl_m;
   logic ovf_m;
   logic [31:0] rd;
   logic err;
   // Control, operand A, operand B of each step
   logic [39:0] ops [19] = '{40'h02_7FFF_7FFF, 40'h00_0003_FFFB, 40'h04_0003_FFFB,
      40'h06_0002_0004, 40'h40_0100_0010, 40'h42_0100_0010, 40'h44_0020_0003,
      40'h46_0020_0003, 40'h01_FFFF_FFFF, 40'h03_FFFF_FFFF, 40'h07_1234_5678,
      40'h01_0002_0002, 40'h07_0003_0003, 40'h05_0002_0003, 40'h12_8000_0000,
      40'h16_0005_0000, 40'h0B_0010_0000, 40'h08_FFFF_0000, 40'h05_0004_0004};

   mau_top u_mau_top (
      .CORE_CLK(CORE_CLK),
      .RST_N(RST_N),
      .PSEL(PSEL),
      .PENABLE(PENABLE),
      .PWRITE(PWRITE),
      .PADDR(PADDR),
      .PWDATA(PWDATA),
      .PRDATA(PRDATA),
      .PREADY(PREADY),
      .PSLVERR(PSLVERR)
   );

   initial begin
      forever #2 CORE_CLK = ~CORE_CLK;
   end

   // Sized well above the roughly nine hundred cycles the sequence needs
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Request held until the rising edge that samples pready high; answer taken there
   task automatic apb_xfer(input logic is_wr, input logic [5:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= is_wr;
      PADDR <= {idx, 2'b00};
      PWDATA <= wd;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      @(posedge CORE_CLK);
      while (PREADY !== 1'b1 && n < 50) begin
         n++;
         @(posedge CORE_CLK);
      end
      check("pready", 32'h1, {31'h0, PREADY});
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb_xfer

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      apb_xfer(1'b1, idx, {16'h0000, d});
      check("write pslverr", 32'h0, {31'h0, err});
   endtask : wr

   task automatic rd_chk(input string name, input logic [5:0] idx, input logic [15:0] exp);
      apb_xfer(1'b0, idx, 32'h0000_0000);
      check(name, {16'h0000, exp}, rd);
      check("read pslverr", 32'h0, {31'h0, err});
   endtask : rd_chk

   // Product and operation result from the current model state
   task automatic calc(output logic [47:0] p, output logic [47:0] r, output logic o);
      logic [48:0] s;
      if (ctrl_m[0]) p = a_m * b_m;
      else p = $signed(a_m) * $signed(b_m);
      s = ctrl_m[2] ? {1'b0, acc_m} - {1'b0, p} : {1'b0, acc_m} + {1'b0, p};
      if (ctrl_m[1]) r = s[47:0];
      else r = ctrl_m[2] ? -p : p;
      if (ctrl_m[0]) o = s[48];
      else o = (ctrl_m[2] ? acc_m[47] != p[47] : acc_m[47] == p[47]) && r[47] != acc_m[47];
   endtask : calc

   task automatic check_state();
      logic [47:0] p;
      logic [47:0] r;
      logic [47:0] res;
      logic o;
      calc(p, r, o);
      // Double counting with accumulation into the accumulator is intended
      res = ctrl_m[1] ? (ctrl_m[2] ? acc_m - p : acc_m + p) : r;
      rd_chk("control", mau_pkg::IDX_CTRL, {8'h00, ovf_m, ctrl_m[6:0]});
      rd_chk("operand a", mau_pkg::IDX_OPA, a_m);
      rd_chk("operand b", mau_pkg::IDX_OPB, b_m);
      rd_chk("acc top", mau_pkg::IDX_ACC_TOP, acc_m[47:32]);
      rd_chk("acc middle", mau_pkg::IDX_ACC_MID, acc_m[31:16]);
      rd_chk("acc bottom", mau_pkg::IDX_ACC_BOT, acc_m[15:0]);
      rd_chk("result high", mau_pkg::IDX_RES_HI, res[31:16]);
      rd_chk("result low", mau_pkg::IDX_RES_LO, res[15:0]);
   endtask : check_state

   task automatic model_op();
      logic [47:0] p;
      logic [47:0] r;
      logic o;
      calc(p, r, o);
      ovf_m = ctrl_m[1] ? o : ctrl_m[2] && ctrl_m[0];
      if (!ctrl_m[6]) acc_m = r;
   endtask : model_op

   task automatic do_op(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b);
      wr(mau_pkg::IDX_CTRL, {8'h00, c});
      ctrl_m = c;
      wr(mau_pkg::IDX_OPA, a);
      a_m = a;
      if (c[4]) b_m = a;
      if (!c[4] && !c[3]) begin
         wr(mau_pkg::IDX_OPB, b);
         b_m = b;
      end
      model_op();
      check_state();
   endtask : do_op

   task automatic zero_model();
      acc_m = 48'h0000_0000_0000;
      a_m = 16'h0000;
      b_m = 16'h0000;
      ctrl_m = 8'h00;
      ovf_m = 1'b0;
   endtask : zero_model

   initial begin
      zero_model();
      repeat (6) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      check_state();
      wr(mau_pkg::IDX_ACC_TOP, 16'h7FFF);
      wr(mau_pkg::IDX_ACC_MID, 16'hFFFF);
      wr(mau_pkg::IDX_ACC_BOT, 16'h0000);
      acc_m = 48'h7FFF_FFFF_0000;
      for (int i = 0; i < 19; i++) begin
         do_op(ops[i][39:32], ops[i][31:16], ops[i][15:0]);
      end
      // Overflow is set here; clearing wipes data and stores the other written control bits
      apb_xfer(1'b1, mau_pkg::IDX_CTRL, 32'hFFFF_FFFF);
      zero_model();
      ctrl_m = 8'h5F;
      check_state();
      wr(mau_pkg::IDX_RES_HI, 16'hABCD);
      wr(mau_pkg::IDX_RES_LO, 16'h1234);
      check_state();
      do_op(8'h00, 16'h0003, 16'h0004);
      wr(mau_pkg::IDX_OPA, 16'h0005);
      wr(mau_pkg::IDX_OPA, 16'h0006);
      a_m = 16'h0006;
      check_state();
      wr(mau_pkg::IDX_CTRL, 16'h0000);
      wr(mau_pkg::IDX_OPB, 16'h0007);
      b_m = 16'h0007;
      check_state();
      wr(mau_pkg::IDX_OPA, 16'h0002);
      a_m = 16'h0002;
      model_op();
      check_state();
      apb_xfer(1'b0, 6'h06, 32'h0000_0000);
      check("unmapped read error", 32'h1, {31'h0, err});
      check("unmapped read data", 32'h0, rd);
      apb_xfer(1'b1, 6'h3F, 32'h0000_5555);
      check("unmapped write error", 32'h1, {31'h0, err});
      check_state();
      @(posedge CORE_CLK);
      RST_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      zero_model();
      check_state();
      stop_test();
   end
endmodule : test_mau_top
`default_nettype wire
